// ===== rtl/acc_pkg.sv
`default_nettype none
package acc_pkg;
    // Register word indices; byte address is four times the index
    localparam logic [4:0]  CHOP_CONFIG_IDX    = 5'h06;
    localparam logic [4:0]  SPARE_A_IDX        = 5'h07;
    localparam logic [4:0]  SPARE_B_IDX        = 5'h08;
    localparam logic [4:0]  CH0_CONFIG_IDX     = 5'h09;
    localparam logic [4:0]  CH0_OFFSET_HI_IDX  = 5'h0A;
    localparam logic [4:0]  CH0_OFFSET_LO_IDX  = 5'h0B;
    localparam logic [4:0]  CH0_GAIN_HI_IDX    = 5'h0C;
    localparam logic [4:0]  CH0_GAIN_LO_IDX    = 5'h0D;
    localparam logic [4:0]  RESULT_IDX         = 5'h10;
    localparam logic [4:0]  STATUS_IDX         = 5'h11;
    // Reset values
    localparam logic [15:0] CHOP_CONFIG_RST    = 16'h0600;
    localparam logic [15:0] SPARE_A_RST        = 16'h0000;
    localparam logic [15:0] SPARE_B_RST        = 16'h0000;
    localparam logic [15:0] CH0_CONFIG_RST     = 16'h0000;
    localparam logic [15:0] CH0_OFFSET_HI_RST  = 16'h0000;
    localparam logic [15:0] CH0_OFFSET_LO_RST  = 16'h0000;
    localparam logic [15:0] CH0_GAIN_HI_RST    = 16'h8000;
    localparam logic [15:0] CH0_GAIN_LO_RST    = 16'h0000;
    // Writable masks
    localparam logic [15:0] CHOP_CONFIG_WMASK  = 16'hFFFF;
    localparam logic [15:0] SPARE_B_WMASK      = 16'hFF0F;
    localparam logic [15:0] CH0_CONFIG_WMASK   = 16'hFFC7;
    localparam logic [15:0] OFFSET_LO_WMASK    = 16'hFF00;
    // Field positions
    localparam int          CHOP_DELAY_LSB     = 9;
    localparam int          CHOP_DELAY_MSB     = 12;
    localparam int          CHOP_ON_BIT        = 8;
    localparam int          INPUT_SEL_LSB      = 0;
    localparam int          INPUT_SEL_MSB      = 1;
    // Input select codes
    typedef enum logic [1:0] {
        ACC_SEL_PINS    = 2'h0,
        ACC_SEL_SHORTED = 2'h1,
        ACC_SEL_TEST_P  = 2'h2,
        ACC_SEL_TEST_N  = 2'h3
    } acc_sel_t;
    // Settle codes decoded apart from the shift; only 1101b leaves the power of two pattern
    localparam logic [3:0]  DLY_CODE_ODD       = 4'hD;
    localparam logic [3:0]  DLY_CODE_UNDEF     = 4'hE;
    localparam logic [16:0] DLY_ODD_PERIODS    = 17'd16484;
    localparam logic [16:0] DLY_UNDEF_PERIODS  = 17'd32768;
endpackage
`default_nettype wire

// ===== rtl/acc_corr.sv
`default_nettype none
// Offset then gain correction of one 24-bit result, registered
module acc_corr
    import acc_pkg::*;
#(
    parameter int W = 24
) (
    input  wire logic         core_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         valid_i,
    input  wire logic [W-1:0] sample_i,
    input  wire logic [W-1:0] offset_i,
    input  wire logic [W-1:0] gain_i,
    output logic              valid_o,
    output logic [W-1:0]      result_o
);
    logic signed [W:0]     sum;
    logic signed [2*W+1:0] prod;
    logic signed [W+1:0]   scaled;
    logic [W-1:0]          sat;
    logic [W-1:0]          result_d;
    logic                  valid_d;

    always_comb begin
        sum    = $signed({sample_i[W-1], sample_i}) + $signed({offset_i[W-1], offset_i});
        prod   = $signed(sum) * $signed({1'b0, gain_i});
        // Gain of 2^(W-1) is unity
        scaled = prod[2*W:W-1];
        // Saturate instead of wrapping, a wrap flips sign
        if (scaled > $signed({3'h0, {(W-1){1'b1}}})) begin
            sat = {1'b0, {(W-1){1'b1}}};
        end else if (scaled < $signed({3'h7, {(W-1){1'b0}}})) begin
            sat = {1'b1, {(W-1){1'b0}}};
        end else begin
            sat = scaled[W-1:0];
        end
        result_d = valid_i ? sat : result_o;
        valid_d  = valid_i;
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            result_o <= '0;
            valid_o  <= 1'b0;
        end else begin
            result_o <= result_d;
            valid_o  <= valid_d;
        end
    end
endmodule // acc_corr
`default_nettype wire

// ===== rtl/acc_regs.sv
// The Avalon-MM slave port was decided locally.
`default_nettype none
module acc_regs
    import acc_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    // Avalon-MM slave
    input  wire logic [6:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    output logic [1:0]       avs_response_o,
    // Conversion stream, same clock
    input  wire logic        sample_valid_i,
    input  wire logic [23:0] sample_i,
    output logic             result_valid_o,
    output logic [23:0]      result_o,
    // Analog control
    output logic             chop_on_o,
    output logic [16:0]      chop_settle_delay_o,
    output acc_sel_t         ch0_input_select_o
);
    ////////////////////////////////////////////////////////////////////
    logic [15:0] chop_config_q, chop_config_d;
    logic [15:0] spare_a_q, spare_a_d;
    logic [15:0] spare_b_q, spare_b_d;
    logic [15:0] ch0_config_q, ch0_config_d;
    logic [15:0] ch0_offset_hi_q, ch0_offset_hi_d;
    logic [15:0] ch0_offset_lo_q, ch0_offset_lo_d;
    logic [15:0] ch0_gain_hi_q, ch0_gain_hi_d;
    logic [15:0] ch0_gain_lo_q, ch0_gain_lo_d;
    logic        ack_q, ack_d;
    logic        wait_q, wait_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0]  resp_q, resp_d;
    logic        chop_on_q, chop_on_d;
    logic [16:0] delay_q, delay_d;
    acc_sel_t    sel_q, sel_d;
    logic [4:0]  idx;
    logic [15:0] wmask;
    logic [15:0] wdata;
    logic        wr_go;
    logic        rd_go;
    logic        hit;
    logic [15:0] rword;
    logic        corr_valid;
    logic [23:0] corr_result;

    assign idx   = avs_address_i[6:2];
    assign wdata = avs_writedata_i[15:0];
    assign wmask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    // One wait cycle: the request is taken when ack rises
    assign wr_go = avs_write_i && !ack_q;
    assign rd_go = avs_read_i && !ack_q;

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [15:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        chop_config_d   = chop_config_q;
        spare_a_d       = spare_a_q;
        spare_b_d       = spare_b_q;
        ch0_config_d    = ch0_config_q;
        ch0_offset_hi_d = ch0_offset_hi_q;
        ch0_offset_lo_d = ch0_offset_lo_q;
        ch0_gain_hi_d   = ch0_gain_hi_q;
        ch0_gain_lo_d   = ch0_gain_lo_q;
        hit             = 1'b1;
        rword           = 16'h0000;
        unique case (idx)
            CHOP_CONFIG_IDX:   rword = chop_config_q;
            SPARE_A_IDX:       rword = spare_a_q;
            SPARE_B_IDX:       rword = spare_b_q;
            CH0_CONFIG_IDX:    rword = ch0_config_q;
            CH0_OFFSET_HI_IDX: rword = ch0_offset_hi_q;
            CH0_OFFSET_LO_IDX: rword = ch0_offset_lo_q;
            CH0_GAIN_HI_IDX:   rword = ch0_gain_hi_q;
            CH0_GAIN_LO_IDX:   rword = ch0_gain_lo_q;
            RESULT_IDX:        rword = result_o[23:8];
            STATUS_IDX:        rword = {8'h00, result_o[7:0]};
            default:           hit = 1'b0;
        endcase
        if (wr_go) begin
            unique case (idx)
                CHOP_CONFIG_IDX:   chop_config_d = merge(chop_config_q, wdata, wmask & CHOP_CONFIG_WMASK);
                SPARE_A_IDX:       spare_a_d = merge(spare_a_q, wdata, wmask);
                SPARE_B_IDX:       spare_b_d = merge(spare_b_q, wdata, wmask & SPARE_B_WMASK);
                CH0_CONFIG_IDX:    ch0_config_d = merge(ch0_config_q, wdata, wmask & CH0_CONFIG_WMASK);
                CH0_OFFSET_HI_IDX: ch0_offset_hi_d = merge(ch0_offset_hi_q, wdata, wmask);
                CH0_OFFSET_LO_IDX: ch0_offset_lo_d = merge(ch0_offset_lo_q, wdata, wmask & OFFSET_LO_WMASK);
                CH0_GAIN_HI_IDX:   ch0_gain_hi_d = merge(ch0_gain_hi_q, wdata, wmask);
                CH0_GAIN_LO_IDX:   ch0_gain_lo_d = merge(ch0_gain_lo_q, wdata, wmask & OFFSET_LO_WMASK);
                default:           ;
            endcase
        end
        ack_d   = (avs_read_i || avs_write_i) && !ack_q;
        // Own flop so the handshake output carries no gate after the register
        wait_d  = !ack_d;
        rdata_d = rd_go ? {16'h0000, rword} : 32'h0000_0000;
        resp_d  = ((rd_go || wr_go) && !hit) ? 2'h3 : 2'h0;
    end

    ////////////////////////////////////////////////////////////////////
    // Decode of control fields into the analog side
    always_comb begin
        chop_on_d = chop_config_q[CHOP_ON_BIT];
        unique case (chop_config_q[CHOP_DELAY_MSB:CHOP_DELAY_LSB])
            DLY_CODE_ODD:   delay_d = DLY_ODD_PERIODS;
            // Code 1110b is undefined; hold it to the neighbouring power of two
            DLY_CODE_UNDEF: delay_d = DLY_UNDEF_PERIODS;
            // Five-bit shift count: code 1111b plus one must not wrap to zero
            default:        delay_d = 17'(17'h1 << ({1'b0, chop_config_q[CHOP_DELAY_MSB:CHOP_DELAY_LSB]} + 5'h01));
        endcase
        sel_d = acc_sel_t'(ch0_config_q[INPUT_SEL_MSB:INPUT_SEL_LSB]);
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            chop_config_q   <= CHOP_CONFIG_RST;
            spare_a_q       <= SPARE_A_RST;
            spare_b_q       <= SPARE_B_RST;
            ch0_config_q    <= CH0_CONFIG_RST;
            ch0_offset_hi_q <= CH0_OFFSET_HI_RST;
            ch0_offset_lo_q <= CH0_OFFSET_LO_RST;
            ch0_gain_hi_q   <= CH0_GAIN_HI_RST;
            ch0_gain_lo_q   <= CH0_GAIN_LO_RST;
            ack_q           <= 1'b0;
            wait_q          <= 1'b1;
            rdata_q         <= 32'h0000_0000;
            resp_q          <= 2'h0;
            chop_on_q       <= 1'b0;
            delay_q         <= 17'h00010;
            sel_q           <= ACC_SEL_PINS;
        end else begin
            chop_config_q   <= chop_config_d;
            spare_a_q       <= spare_a_d;
            spare_b_q       <= spare_b_d;
            ch0_config_q    <= ch0_config_d;
            ch0_offset_hi_q <= ch0_offset_hi_d;
            ch0_offset_lo_q <= ch0_offset_lo_d;
            ch0_gain_hi_q   <= ch0_gain_hi_d;
            ch0_gain_lo_q   <= ch0_gain_lo_d;
            ack_q           <= ack_d;
            wait_q          <= wait_d;
            rdata_q         <= rdata_d;
            resp_q          <= resp_d;
            chop_on_q       <= chop_on_d;
            delay_q         <= delay_d;
            sel_q           <= sel_d;
        end
    end

    assign avs_waitrequest_o   = wait_q;
    assign avs_readdata_o      = rdata_q;
    assign avs_response_o      = resp_q;
    assign chop_on_o           = chop_on_q;
    assign chop_settle_delay_o = delay_q;
    assign ch0_input_select_o  = sel_q;

    ////////////////////////////////////////////////////////////////////
    // Correction path; waitrequest is low for one cycle and is a flop
    acc_corr #(.W(24)) u_corr (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .valid_i    (sample_valid_i),
        .sample_i   (sample_i),
        .offset_i   ({ch0_offset_hi_q, ch0_offset_lo_q[15:8]}),
        .gain_i     ({ch0_gain_hi_q, ch0_gain_lo_q[15:8]}),
        .valid_o    (corr_valid),
        .result_o   (corr_result)
    );
    assign result_valid_o = corr_valid;
    assign result_o       = corr_result;

    ////////////////////////////////////////////////////////////////////
    // Control fields and their decode
    chop_off_rst_a: assert property (@(posedge core_clk_i) $rose(rst_n_i) |-> !chop_on_o)
        else $error("chop on after reset");
    chop_follow_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        $changed(chop_config_q[CHOP_ON_BIT]) |=> chop_on_o == $past(chop_config_q[CHOP_ON_BIT]))
        else $error("chop enable not followed");
    chop_wr_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        wr_go && idx == CHOP_CONFIG_IDX && avs_byteenable_i[1:0] == 2'h3
        |=> chop_config_q == $past(wdata))
        else $error("chop config write lost");
    delay_rst_a: assert property (@(posedge core_clk_i) $rose(rst_n_i) |-> chop_settle_delay_o == 17'd16)
        else $error("settle delay reset wrong");
    delay_odd_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        chop_config_q[12:9] == 4'hD |=> delay_q == 17'd16484)
        else $error("odd delay code wrong");
    delay_zero_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        chop_config_q[12:9] == 4'h0 |=> delay_q == 17'd2)
        else $error("delay code zero wrong");
    delay_mid_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        chop_config_q[12:9] == 4'h9 |=> delay_q == 17'd1024)
        else $error("delay code nine wrong");
    delay_max_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        chop_config_q[12:9] == 4'hF |=> delay_q == 17'h10000)
        else $error("delay code max wrong");
    delay_undef_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        chop_config_q[12:9] == 4'hE |=> delay_q == 17'd32768)
        else $error("undefined delay code wrong");

    // Spare and channel registers
    spare_rst_a: assert property (@(posedge core_clk_i) $rose(rst_n_i)
        |-> spare_a_q == 16'h0000 && spare_b_q == 16'h0000)
        else $error("spare reset value wrong");
    spare_b_ro_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        spare_b_q[7:4] == 4'h0)
        else $error("spare b read-only bits set");
    spare_a_wr_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        wr_go && idx == SPARE_A_IDX && avs_byteenable_i[1:0] == 2'h3 |=> spare_a_q == $past(wdata))
        else $error("spare a write lost");
    spare_b_wr_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        wr_go && idx == SPARE_B_IDX && avs_byteenable_i[1:0] == 2'h3
        |=> spare_b_q == ($past(wdata) & 16'hFF0F))
        else $error("spare b write wrong");
    cfg_rst_a: assert property (@(posedge core_clk_i) $rose(rst_n_i)
        |-> ch0_config_q == 16'h0000 && ch0_input_select_o == ACC_SEL_PINS)
        else $error("channel config reset wrong");
    cfg_ro_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        ch0_config_q[5:3] == 3'h0)
        else $error("config read-only bits set");
    cfg_wr_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        wr_go && idx == CH0_CONFIG_IDX && avs_byteenable_i[1:0] == 2'h3
        |=> ch0_config_q == ($past(wdata) & 16'hFFC7))
        else $error("channel config write wrong");
    sel_follow_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        ##1 ch0_input_select_o == $past(ch0_config_q[1:0]))
        else $error("input select lags");

    // Calibration registers
    offs_rst_a: assert property (@(posedge core_clk_i) $rose(rst_n_i)
        |-> ch0_offset_hi_q == 16'h0000 && ch0_offset_lo_q == 16'h0000)
        else $error("offset reset value wrong");
    off_lo_ro_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        ch0_offset_lo_q[7:0] == 8'h00)
        else $error("offset low byte set");
    offs_wr_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        wr_go && idx == CH0_OFFSET_HI_IDX && avs_byteenable_i[1:0] == 2'h3
        |=> ch0_offset_hi_q == $past(wdata))
        else $error("offset upper write lost");
    offs_lo_wr_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        wr_go && idx == CH0_OFFSET_LO_IDX && avs_byteenable_i[1]
        |=> ch0_offset_lo_q[15:8] == $past(wdata[15:8]))
        else $error("offset lower write lost");
    gain_rst_a: assert property (@(posedge core_clk_i) $rose(rst_n_i) |-> ch0_gain_hi_q == 16'h8000)
        else $error("gain reset value wrong");
    gain_wr_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        wr_go && idx == CH0_GAIN_HI_IDX && avs_byteenable_i[1:0] == 2'h3
        |=> ch0_gain_hi_q == $past(wdata))
        else $error("gain upper write lost");
    gain_rd_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        rd_go && idx == CH0_GAIN_HI_IDX |=> avs_readdata_o == {16'h0000, $past(ch0_gain_hi_q)})
        else $error("gain upper read wrong");
    gain_lo_ro_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        ch0_gain_lo_q[7:0] == 8'h00)
        else $error("gain low byte set");
    cal_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !wr_go |=> $stable(ch0_offset_hi_q) && $stable(ch0_gain_hi_q))
        else $error("calibration moved without write");

    // Correction path
    res_rst_a: assert property (@(posedge core_clk_i) $rose(rst_n_i)
        |-> !result_valid_o && result_o == 24'h000000)
        else $error("result reset wrong");
    corr_lat_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        sample_valid_i |=> result_valid_o)
        else $error("result not delivered");
    res_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !sample_valid_i |=> $stable(result_o) && !result_valid_o)
        else $error("result moved without sample");

    // Bus handshake: one wait state, answer stands one cycle
    wait_rst_a: assert property (@(posedge core_clk_i) $rose(rst_n_i) |-> avs_waitrequest_o)
        else $error("waitrequest low after reset");
    wait_answer_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("request not answered");
    wait_one_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("answer stands too long");
    resp_bad_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (rd_go || wr_go) && !hit |=> avs_response_o == 2'h3)
        else $error("unmapped access not flagged");
    resp_good_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (rd_go || wr_go) && hit |=> avs_response_o == 2'h0)
        else $error("mapped access flagged");
endmodule // acc_regs
`default_nettype wire

// ===== sim/acc_regs_tb.sv
`default_nettype none
module acc_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import acc_pkg::*;

    logic        core_clk_i;
    logic        rst_n_i;
    logic [6:0]  avs_address_i;
    logic        avs_read_i;
    logic        avs_write_i;
    logic [31:0] avs_writedata_i;
    logic [3:0]  avs_byteenable_i;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic [1:0]  avs_response_o;
    logic        sample_valid_i;
    logic [23:0] sample_i;
    logic        result_valid_o;
    logic [23:0] result_o;
    logic        chop_on_o;
    logic [16:0] chop_settle_delay_o;
    acc_sel_t    ch0_input_select_o;
    int          num_errors;
    int          n_compared;

    acc_regs i_acc_regs (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .avs_response_o(avs_response_o),
        .sample_valid_i(sample_valid_i), .sample_i(sample_i), .result_valid_o(result_valid_o),
        .result_o(result_o), .chop_on_o(chop_on_o), .chop_settle_delay_o(chop_settle_delay_o),
        .ch0_input_select_o(ch0_input_select_o));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Holds the request until waitrequest is sampled low; bounded so a dead slave cannot hang us
    task automatic bus(input logic wr, input logic [4:0] idx, input logic [15:0] wd,
                       output logic [31:0] rd, output logic [1:0] resp);
        int n;
        n = 0;
        @(posedge core_clk_i);
        avs_address_i   <= {idx, 2'b00};
        avs_read_i      <= !wr;
        avs_write_i     <= wr;
        avs_writedata_i <= {16'h0000, wd};
        do begin
            @(posedge core_clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 20);
        rd = avs_readdata_o;
        resp = avs_response_o;
        if (n >= 20) check("bus answer", 32'h1, 32'h0);
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] idx, input logic [15:0] wd);
        logic [31:0] rd;
        logic [1:0]  rsp;
        bus(1'b1, idx, wd, rd, rsp);
    endtask

    task automatic rd_chk(input string name, input logic [4:0] idx, input logic [15:0] exp);
        logic [31:0] rd;
        logic [1:0]  rsp;
        bus(1'b0, idx, 16'h0000, rd, rsp);
        check(name, rd, {16'h0000, exp});
        check("response", {30'h0, rsp}, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_reset_and_masks();
        logic [4:0]  idx [7] = '{SPARE_A_IDX, SPARE_B_IDX, CH0_CONFIG_IDX, CH0_OFFSET_HI_IDX,
                                 CH0_OFFSET_LO_IDX, CH0_GAIN_HI_IDX, CH0_GAIN_LO_IDX};
        logic [15:0] rst [7] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0000};
        // Reserved writable bits only ever get zeros; ones go to data and read-only bits
        logic [15:0] put [7] = '{16'h0000, 16'h00F0, 16'h003B, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
        logic [15:0] all [7] = '{16'h0000, 16'h0000, 16'h0003, 16'hFFFF, 16'hFF00, 16'hFFFF, 16'hFF00};
        check("chop on", {31'h0, chop_on_o}, 32'h0);
        check("settle", {15'h0, chop_settle_delay_o}, 32'd16);
        check("select", {30'h0, ch0_input_select_o}, 32'h0);
        rd_chk("chop cfg rst", CHOP_CONFIG_IDX, 16'h0600);
        for (int i = 0; i < 7; i++) begin
            rd_chk("reset value", idx[i], rst[i]);
            wr(idx[i], put[i]);
            rd_chk("ones readback", idx[i], all[i]);
            wr(idx[i], rst[i]);
            rd_chk("restored", idx[i], rst[i]);
        end
        $display("test reset_and_masks done");
    endtask

    task automatic test_unmapped();
        logic [31:0] rd;
        logic [1:0]  rsp;
        bus(1'b1, 5'h1F, 16'h1234, rd, rsp);
        check("unmapped wr resp", {30'h0, rsp}, 32'h3);
        bus(1'b0, 5'h1F, 16'h0000, rd, rsp);
        check("unmapped data", rd, 32'h0);
        check("unmapped resp", {30'h0, rsp}, 32'h3);
        rd_chk("spare after", SPARE_A_IDX, 16'h0000);
        avs_byteenable_i <= 4'h2;
        wr(CH0_OFFSET_HI_IDX, 16'hABCD);
        avs_byteenable_i <= 4'h3;
        rd_chk("lane 1 only", CH0_OFFSET_HI_IDX, 16'hAB00);
        wr(CH0_OFFSET_HI_IDX, 16'h0000);
        $display("test unmapped done");
    endtask

    // Every delay code, with chop toggled alongside so both fields move
    task automatic test_delay();
        logic [16:0] exp;
        for (int c = 0; c < 16; c++) begin
            exp = (c == 13) ? 17'd16484 : (c == 14) ? 17'd32768 : (17'd1 << (c + 1));
            wr(CHOP_CONFIG_IDX, {3'h0, 4'(c), 1'(c), 8'h00});
            @(posedge core_clk_i);
            #1;
            check("settle", {15'h0, chop_settle_delay_o}, {15'h0, exp});
            check("chop on", {31'h0, chop_on_o}, {31'h0, 1'(c)});
            rd_chk("chop cfg", CHOP_CONFIG_IDX, {3'h0, 4'(c), 1'(c), 8'h00});
        end
        $display("test delay done");
    endtask

    task automatic test_select();
        for (int s = 0; s < 4; s++) begin
            wr(CH0_CONFIG_IDX, {14'h0, 2'(s)});
            @(posedge core_clk_i);
            #1;
            check("select", {30'h0, ch0_input_select_o}, 32'(s));
        end
        wr(CH0_CONFIG_IDX, 16'h0000);
        $display("test select done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [23:0] corr(input logic [23:0] s, input logic [23:0] o, input logic [23:0] g);
        longint v;
        v = ((longint'($signed(s)) + longint'($signed(o))) * longint'({1'b0, g})) >>> 23;
        if (v > 64'sh7FFFFF) v = 64'sh7FFFFF;
        if (v < -64'sh800000) v = -64'sh800000;
        return v[23:0];
    endfunction

    task automatic test_corr();
        logic [15:0] ohi [5] = '{16'h0001, 16'hFFFF, 16'h0001, 16'h0001, 16'h0001};
        logic [15:0] olo [5] = '{16'h2000, 16'h0000, 16'h2000, 16'h2000, 16'h2000};
        logic [15:0] ghi [5] = '{16'h8000, 16'h8000, 16'h4000, 16'hC000, 16'h8000};
        logic [23:0] smp [5] = '{24'h000100, 24'h000100, 24'h000100, 24'h000100, 24'h7FFFFF};
        logic [23:0] exp;
        for (int i = 0; i < 5; i++) begin
            wr(CH0_OFFSET_HI_IDX, ohi[i]);
            wr(CH0_OFFSET_LO_IDX, olo[i]);
            wr(CH0_GAIN_HI_IDX, ghi[i]);
            @(posedge core_clk_i);
            sample_valid_i <= 1'b1;
            sample_i       <= smp[i];
            @(posedge core_clk_i);
            sample_valid_i <= 1'b0;
            sample_i       <= 24'h000000;
            #1;
            exp = corr(smp[i], {ohi[i], olo[i][15:8]}, {ghi[i], 8'h00});
            check("result valid", {31'h0, result_valid_o}, 32'h1);
            check("result", {8'h0, result_o}, {8'h0, exp});
            rd_chk("result upper", RESULT_IDX, exp[23:8]);
            rd_chk("result lower", STATUS_IDX, {8'h00, exp[7:0]});
        end
        $display("test corr done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end

    initial begin
        #(20000 * 40);
        num_errors++;
        test_done();
    end

    initial begin
        num_errors = 0;
        n_compared = 0;
        rst_n_i = 1'b0;
        avs_address_i = 7'h00;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_writedata_i = 32'h0;
        avs_byteenable_i = 4'h3;
        sample_valid_i = 1'b0;
        sample_i = 24'h0;
        repeat (3) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        @(posedge core_clk_i);
        #1;
        test_reset_and_masks();
        test_unmapped();
        test_delay();
        test_select();
        test_corr();
        test_done();
    end
endmodule // acc_regs_tb
`default_nettype wire
